/* common/pll_clk_pkg.sv */
// Shared constants and types for the PLL bandwidth and base clock select block.
// Assumes a 32-bit APB slave with each register in one aligned word.
package pll_clk_pkg;
    // ************************************************************
    // Register map: printed indices, byte address is four times the index.
    // ************************************************************
    localparam logic [7:0] CTRL_INDEX = 8'h1C;
    localparam logic [7:0] BW_INDEX = 8'h1D;
    localparam logic [7:0] PROG_INDEX = 8'h1E;
    localparam logic [7:0] CTRL_ADDR = {CTRL_INDEX[5:0], 2'b00};
    localparam logic [7:0] BW_ADDR = {BW_INDEX[5:0], 2'b00};
    localparam logic [7:0] PROG_ADDR = {PROG_INDEX[5:0], 2'b00};

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CTRL_IRQ_EN_BIT = 7;
    localparam int CTRL_FLAG_BIT = 6;
    localparam int CTRL_RUN_BIT = 5;
    localparam int CTRL_SEL_BIT = 4;
    localparam logic [3:0] CTRL_UNUSED_READ = 4'hF;
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_TRACK_BIT = 5;

    // ************************************************************
    // Reset values and counts.
    // ************************************************************
    localparam logic RUN_RESET = 1'b1;
    localparam logic [3:0] MUL_RESET = 4'h6;
    localparam logic [3:0] RANGE_RESET = 4'h7;
    localparam logic [3:0] MUL_ZERO_AS = 4'h1;
    localparam logic [1:0] SWITCH_EDGES = 2'd3;

    // Tolerance comparator outputs from the analog lock detector.
    typedef struct packed {
        logic track_in;
        logic untrack_out;
        logic lock_in;
        logic unlock_out;
    } band_type;

    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_FILL} switch_type;
endpackage

/* design/pll_clk_ctrl.sv */
// PLL digital control: bandwidth mode, lock status, program register and
// glitch-free base clock selection with divide by two.
// Assumes APB on pclk; crystal, VCO and comparator levels arrive asynchronously
// and are sampled on pclk, so both source clocks must run below pclk / 4.
//
// Implementation choices: the register offsets and register access over APB.

// ************************************************************
// Three-stage level synchroniser.
// ************************************************************
module level_sync (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous level and its settled copy.
    input wire logic din,
    output logic dout
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic dout_reg;
    logic dout_next;

    // A change counts only once the second and third stages agree.
    always_comb begin
        stage_next = {stage_reg[1:0], din};
        dout_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[1] : dout_reg;
    end

    // State registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_reg <= 3'b000;
            dout_reg <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            dout_reg <= dout_next;
        end
    end

    assign dout = dout_reg;
endmodule

module pll_clk_ctrl (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Source clocks and analog comparators.
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire pll_clk_pkg::band_type band,
    input wire logic stop_req,
    // Clock and loop outputs.
    output logic base_clock_out,
    output logic pll_irq,
    output logic synth_enable,
    output logic filter_track,
    output logic [3:0] feedback_div,
    output logic [3:0] range_mult
);
    import pll_clk_pkg::*;

    // ************************************************************
    // Input synchronisers.
    // ************************************************************
    logic xtal_lvl;
    logic vco_lvl;
    band_type band_s;

    // Analog comparators settle through the same filter as the clocks.
    level_sync u_xtal (.pclk(pclk), .presetn(presetn), .din(crystal_clock), .dout(xtal_lvl));
    level_sync u_vco (.pclk(pclk), .presetn(presetn), .din(vco_clock), .dout(vco_lvl));
    level_sync u_trk (.pclk(pclk), .presetn(presetn), .din(band.track_in),
        .dout(band_s.track_in));
    level_sync u_unt (.pclk(pclk), .presetn(presetn), .din(band.untrack_out),
        .dout(band_s.untrack_out));
    level_sync u_lck (.pclk(pclk), .presetn(presetn), .din(band.lock_in),
        .dout(band_s.lock_in));
    level_sync u_unl (.pclk(pclk), .presetn(presetn), .din(band.unlock_out),
        .dout(band_s.unlock_out));

    // ************************************************************
    // Register state.
    // ************************************************************
    logic irq_en_reg, irq_en_next;
    logic flag_reg, flag_next;
    logic run_reg, run_next;
    logic sel_reg, sel_next;
    logic auto_reg, auto_next;
    logic lock_reg, lock_next;
    logic trk_auto_reg, trk_auto_next;
    logic trk_man_reg, trk_man_next;
    logic [7:0] prog_reg, prog_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic synth_reg, synth_next;
    logic track_reg, track_next;
    logic [3:0] fdiv_reg, fdiv_next;
    logic [3:0] range_reg, range_next;
    logic wr_done;
    logic rd_done;
    logic wr_ctrl;
    logic lock_toggle;
    logic mapped;

    // Access completes at the edge where pready is high, one wait state each.
    assign wr_done = psel && penable && pready_reg && pwrite;
    assign rd_done = psel && penable && pready_reg && !pwrite;
    assign wr_ctrl = wr_done && (paddr == CTRL_ADDR);
    assign mapped = (paddr == CTRL_ADDR) || (paddr == BW_ADDR) || (paddr == PROG_ADDR);

    // Next state of the control, status and program registers.
    always_comb begin
        logic new_run;
        logic new_sel;
        new_run = pwdata[CTRL_RUN_BIT];
        new_sel = pwdata[CTRL_SEL_BIT];
        irq_en_next = irq_en_reg;
        run_next = run_reg;
        sel_next = sel_reg;
        auto_next = auto_reg;
        trk_auto_next = trk_auto_reg;
        trk_man_next = trk_man_reg;
        prog_next = prog_reg;
        lock_next = lock_reg;
        // Band entry wins over exit if both comparators fire at once.
        if (auto_reg) begin
            if (band_s.track_in) begin
                trk_auto_next = 1'b1;
            end else if (band_s.untrack_out) begin
                trk_auto_next = 1'b0;
            end
            if (band_s.lock_in) begin
                lock_next = 1'b1;
            end else if (band_s.unlock_out) begin
                lock_next = 1'b0;
            end
        end else begin
            lock_next = 1'b0;
        end
        lock_toggle = auto_reg && (lock_next != lock_reg);
        if (wr_ctrl) begin
            if (auto_reg) begin
                irq_en_next = pwdata[CTRL_IRQ_EN_BIT];
            end
            // A write that flips both run and select leaves both unchanged; in automatic mode the interrupt enable still takes its bit.
            if (!((new_run != run_reg) && (new_sel != sel_reg))) begin
                if (new_run || !sel_reg) begin
                    run_next = new_run;
                end
                if (!new_sel || (run_reg && (prog_reg[3:0] != 4'h0))) begin
                    sel_next = new_sel;
                end
            end
        end
        if (wr_done && (paddr == BW_ADDR)) begin
            auto_next = pwdata[BW_AUTO_BIT];
            if (!auto_reg) begin
                trk_man_next = pwdata[BW_TRACK_BIT];
            end
        end
        if (wr_done && (paddr == PROG_ADDR)) begin
            prog_next = pwdata[7:0];
        end
        if (stop_req || (prog_next[3:0] == 4'h0)) begin
            sel_next = 1'b0;
        end
        // Set wins over the read that clears it.
        flag_next = flag_reg;
        if (rd_done && (paddr == CTRL_ADDR)) begin
            flag_next = 1'b0;
        end
        if (lock_toggle) begin
            flag_next = 1'b1;
        end
        if (!auto_next) begin
            irq_en_next = 1'b0;
            flag_next = 1'b0;
        end
        irq_next = auto_next && irq_en_next && flag_next;
        synth_next = run_next && (prog_next[3:0] != 4'h0);
        track_next = auto_next ? trk_auto_next : trk_man_next;
        fdiv_next = (prog_next[7:4] == 4'h0) ? MUL_ZERO_AS : prog_next[7:4];
        range_next = prog_next[3:0];
        // Read data and handshake.
        pready_next = psel && penable && !pready_reg;
        pslverr_next = pready_next && !mapped;
        prdata_next = 32'h0000_0000;
        if (paddr == CTRL_ADDR) begin
            prdata_next[7:0] = {irq_en_reg, flag_reg, run_reg, sel_reg, CTRL_UNUSED_READ};
        end else if (paddr == BW_ADDR) begin
            prdata_next[7:0] = {auto_reg, lock_reg, track_reg, 5'b00000};
        end else if (paddr == PROG_ADDR) begin
            prdata_next[7:0] = prog_reg;
        end
        if (!pready_next) begin
            prdata_next = prdata_reg;
        end
    end

    // Register update; reset selects the crystal and acquisition mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= 1'b0;
            flag_reg <= 1'b0;
            run_reg <= RUN_RESET;
            sel_reg <= 1'b0;
            auto_reg <= 1'b0;
            lock_reg <= 1'b0;
            trk_auto_reg <= 1'b0;
            trk_man_reg <= 1'b0;
            prog_reg <= {MUL_RESET, RANGE_RESET};
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            synth_reg <= RUN_RESET;
            track_reg <= 1'b0;
            fdiv_reg <= MUL_RESET;
            range_reg <= RANGE_RESET;
        end else begin
            irq_en_reg <= irq_en_next;
            flag_reg <= flag_next;
            run_reg <= run_next;
            sel_reg <= sel_next;
            auto_reg <= auto_next;
            lock_reg <= lock_next;
            trk_auto_reg <= trk_auto_next;
            trk_man_reg <= trk_man_next;
            prog_reg <= prog_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            synth_reg <= synth_next;
            track_reg <= track_next;
            fdiv_reg <= fdiv_next;
            range_reg <= range_next;
        end
    end

    // ************************************************************
    // Base clock selector.
    // ************************************************************
    switch_type sw_reg, sw_next;
    logic active_reg, active_next;
    logic [1:0] cnt_reg, cnt_next;
    logic out_reg, out_next;
    logic xtal_prev_reg;
    logic vco_prev_reg;
    logic xtal_rise;
    logic vco_rise;
    logic src_edge;
    logic dst_edge;

    assign xtal_rise = xtal_lvl && !xtal_prev_reg;
    assign vco_rise = vco_lvl && !vco_prev_reg;
    assign src_edge = active_reg ? vco_rise : xtal_rise;
    assign dst_edge = active_reg ? xtal_rise : vco_rise;

    // A stopped VCO gives no edges, so its drain half is skipped and a fill toward it is abandoned.
    always_comb begin
        sw_next = sw_reg;
        active_next = active_reg;
        cnt_next = cnt_reg;
        out_next = out_reg;
        case (sw_reg)
            SW_RUN: begin
                if (sel_reg != active_reg) begin
                    sw_next = SW_DRAIN;
                    cnt_next = 2'd0;
                end else if (src_edge) begin
                    out_next = !out_reg;
                end
            end
            SW_DRAIN: begin
                if (active_reg && !synth_reg) begin
                    sw_next = SW_FILL;
                    cnt_next = 2'd0;
                end else if (src_edge) begin
                    cnt_next = cnt_reg + 2'd1;
                    if (cnt_next == SWITCH_EDGES) begin
                        sw_next = SW_FILL;
                        cnt_next = 2'd0;
                    end
                end
            end
            SW_FILL: begin
                if (!active_reg && !synth_reg) begin
                    // The VCO died before the handover, so the crystal stays in charge.
                    sw_next = SW_RUN;
                    cnt_next = 2'd0;
                end else if (dst_edge) begin
                    cnt_next = cnt_reg + 2'd1;
                    if (cnt_next == SWITCH_EDGES) begin
                        sw_next = SW_RUN;
                        active_next = !active_reg;
                        cnt_next = 2'd0;
                    end
                end
            end
            default: begin
                sw_next = SW_RUN;
            end
        endcase
    end

    // Selector registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_reg <= SW_RUN;
            active_reg <= 1'b0;
            cnt_reg <= 2'd0;
            out_reg <= 1'b0;
            xtal_prev_reg <= 1'b0;
            vco_prev_reg <= 1'b0;
        end else begin
            sw_reg <= sw_next;
            active_reg <= active_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            xtal_prev_reg <= xtal_lvl;
            vco_prev_reg <= vco_lvl;
        end
    end

    // Outputs come straight from flip-flops.
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign base_clock_out = out_reg;
    assign pll_irq = irq_reg;
    assign synth_enable = synth_reg;
    assign filter_track = track_reg;
    assign feedback_div = fdiv_reg;
    assign range_mult = range_reg;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_manual_no_lock;
        !auto_reg |=> !lock_reg && !flag_reg;
    endproperty
    a_manual_no_lock: assert property (p_manual_no_lock) else $error("lock shown in manual");

    property p_irq_cause;
        pll_irq |-> auto_reg && irq_en_reg && flag_reg;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");

    property p_flag_on_toggle;
        $past(auto_reg) && auto_reg && $changed(lock_reg) |-> flag_reg ##1 (flag_reg || pll_irq == 1'b0);
    endproperty
    a_flag_on_toggle: assert property (p_flag_on_toggle) else $error("flag missed toggle");

    property p_sel_needs_run;
        sel_reg |-> run_reg && synth_enable;
    endproperty
    a_sel_needs_run: assert property (p_sel_needs_run) else $error("VCO selected while off");

    property p_no_dual_change;
        !($changed(run_reg) && $changed(sel_reg));
    endproperty
    a_no_dual_change: assert property (p_no_dual_change) else $error("both bits changed");

    property p_range_zero;
        prog_reg[3:0] == 4'h0 |-> !sel_reg && !synth_enable;
    endproperty
    a_range_zero: assert property (p_range_zero) else $error("range zero not forced");

    property p_stop_clears;
        stop_req |=> !sel_reg;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("stop kept VCO select");

    property p_hold_in_switch;
        sw_reg != SW_RUN |=> $stable(base_clock_out);
    endproperty
    a_hold_in_switch: assert property (p_hold_in_switch) else $error("output moved in switch");

    property p_divide;
        sw_reg == SW_RUN && sel_reg == active_reg && src_edge |=> $changed(base_clock_out);
    endproperty
    a_divide: assert property (p_divide) else $error("output missed source edge");

    property p_mul_zero;
        prog_reg[7:4] == 4'h0 |-> feedback_div == MUL_ZERO_AS;
    endproperty
    a_mul_zero: assert property (p_mul_zero) else $error("zero multiplier not one");

    c_to_vco: cover property (sw_reg == SW_FILL && !active_reg ##1 sw_reg == SW_RUN && active_reg);
    c_irq: cover property ($rose(pll_irq));
    c_dual_refused: cover property (wr_ctrl && (pwdata[CTRL_RUN_BIT] != run_reg)
        && (pwdata[CTRL_SEL_BIT] != sel_reg));
endmodule

/* dv/clock_band_model.sv */
// Far-side model: crystal and VCO sources plus the analog lock detector levels.
// Assumes the bench steers the band levels and the block reports loop-on.
module clock_band_model (
    // Loop state from the block.
    input wire logic synth_enable,
    // Bench commands for the comparator levels.
    input wire logic lock_cmd,
    input wire logic track_cmd,
    // Sources and comparators toward the block.
    output logic crystal_clock,
    output logic vco_clock,
    output pll_clk_pkg::band_type band
);
    timeunit 1ns;
    timeprecision 1ns;
    import pll_clk_pkg::*;

    // ************************************************************
    // Sources.
    // ************************************************************
    // Edges are offset from pclk so the synchronisers never see a tie.
    initial begin
        crystal_clock = 1'b0;
        #23;
        forever #500 crystal_clock = ~crystal_clock;
    end

    // The VCO stands still while the loop is off, as a stopped oscillator does.
    initial begin
        vco_clock = 1'b0;
        #37;
        forever begin
            #250;
            vco_clock = synth_enable ? ~vco_clock : 1'b0;
        end
    end

    // Comparator pairs are always complementary, like a real window detector.
    always_comb begin
        band.track_in = track_cmd;
        band.untrack_out = ~track_cmd;
        band.lock_in = lock_cmd;
        band.unlock_out = ~lock_cmd;
    end
endmodule

/* dv/pll_bandwidth_and_base_clock_select_bench.sv */
// Self-checking bench for the PLL control block over APB.
// Assumes a 1 MHz crystal and 2 MHz VCO from the far-side model.
module pll_bandwidth_and_base_clock_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pll_clk_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crystal_clock;
    logic vco_clock;
    band_type band;
    logic stop_req = 1'b0;
    logic lock_cmd = 1'b0;
    logic track_cmd = 1'b0;
    logic base_clock_out;
    logic pll_irq;
    logic synth_enable;
    logic filter_track;
    logic [3:0] feedback_div;
    logic [3:0] range_mult;
    int n_errors = 0;
    int compares = 0;
    // Software settle times; plain defaults, since the filter parts set the real ones.
    localparam int ACQ_CYCLES = 20;
    localparam int LOCK_CYCLES = 20;
    // Range is derived as software would, for a 32 MHz target VCO.
    localparam real VCO_TARGET_HZ = 32.0e6;
    localparam logic [3:0] RANGE_PICK = 4'(int'(VCO_TARGET_HZ / 4.9152e6));

    // ************************************************************
    // Clock, design and far side.
    // ************************************************************
    initial begin
        forever #50 pclk = ~pclk;
    end

    pll_clk_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_clock(crystal_clock), .vco_clock(vco_clock),
        .band(band), .stop_req(stop_req), .base_clock_out(base_clock_out),
        .pll_irq(pll_irq), .synth_enable(synth_enable), .filter_track(filter_track),
        .feedback_div(feedback_div), .range_mult(range_mult));

    clock_band_model far_side (.synth_enable(synth_enable), .lock_cmd(lock_cmd),
        .track_cmd(track_cmd), .crystal_clock(crystal_clock), .vco_clock(vco_clock),
        .band(band));

    // ************************************************************
    // Helpers.
    // ************************************************************
    task automatic finish_test();
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high at an edge.
    task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) begin
            @(posedge pclk);
        end
        if (i == 20) begin
            n_errors++;
            finish_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h00_0000, d}, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk("read data", q, exp);
        chk("slave error", {31'h0, e}, {31'h0, exp_e});
    endtask

    // Waits a bounded time for a one-bit output to reach a level.
    task automatic wait_bit(input string what, ref logic s, input logic v);
        int i;
        for (i = 0; i < 30 && s !== v; i++) begin
            @(posedge pclk);
        end
        chk(what, {31'h0, s}, {31'h0, v});
        if (s !== v) finish_test();
    endtask

    // Measures base clock period between its third and fourth rise.
    task automatic period(input int exp_ns);
        int i;
        int rises;
        logic prev;
        time t0;
        t0 = 0;
        rises = 0;
        prev = base_clock_out;
        for (i = 0; i < 400 && rises < 4; i++) begin
            @(posedge pclk);
            if (prev === 1'b0 && base_clock_out === 1'b1) begin
                rises++;
                if (rises == 3) t0 = $time;
                if (rises == 4) chk("base period", 32'($time - t0), 32'(exp_ns));
            end
            prev = base_clock_out;
        end
        if (rises < 4) begin
            chk("base rises", 32'(rises), 32'h0000_0004);
            finish_test();
        end
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        int i;
        logic held;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL_ADDR, 32'h0000_002F, 1'b0);
        rd(BW_ADDR, 32'h0000_0000, 1'b0);
        rd(PROG_ADDR, 32'h0000_0067, 1'b0);
        chk("outputs", {22'h0, synth_enable, filter_track, feedback_div, range_mult},
            32'h0000_0267);
        rd(8'h00, 32'h0000_0000, 1'b1);
        // Manual mode: tracking cleared, loop turned on, acquisition waited out.
        wr(CTRL_ADDR, 8'h00);
        wr(BW_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h20);
        repeat (ACQ_CYCLES) @(posedge pclk);
        wr(BW_ADDR, 8'h20);
        wait_bit("manual track", filter_track, 1'b1);
        rd(BW_ADDR, 32'h0000_0020, 1'b0);
        wr(CTRL_ADDR, 8'hA0);
        rd(CTRL_ADDR, 32'h0000_002F, 1'b0);
        wr(BW_ADDR, 8'h00);
        // Automatic mode.
        wr(BW_ADDR, 8'h80);
        wr(BW_ADDR, 8'hA0);
        rd(BW_ADDR, 32'h0000_0080, 1'b0);
        track_cmd <= 1'b1;
        wait_bit("auto track", filter_track, 1'b1);
        rd(BW_ADDR, 32'h0000_00A0, 1'b0);
        track_cmd <= 1'b0;
        wait_bit("auto untrack", filter_track, 1'b0);
        wr(CTRL_ADDR, 8'hA0);
        rd(CTRL_ADDR, 32'h0000_00AF, 1'b0);
        lock_cmd <= 1'b1;
        wait_bit("irq on lock", pll_irq, 1'b1);
        rd(BW_ADDR, 32'h0000_00C0, 1'b0);
        rd(CTRL_ADDR, 32'h0000_00EF, 1'b0);
        rd(CTRL_ADDR, 32'h0000_00AF, 1'b0);
        chk("irq after read", {31'h0, pll_irq}, 32'h0000_0000);
        lock_cmd <= 1'b0;
        wait_bit("irq on unlock", pll_irq, 1'b1);
        rd(BW_ADDR, 32'h0000_0080, 1'b0);
        rd(CTRL_ADDR, 32'h0000_00EF, 1'b0);
        wr(BW_ADDR, 8'h00);
        lock_cmd <= 1'b1;
        repeat (10) @(posedge pclk);
        chk("manual irq", {31'h0, pll_irq}, 32'h0000_0000);
        rd(BW_ADDR, 32'h0000_0000, 1'b0);
        // Program register fields and the zero multiplier.
        wr(PROG_ADDR, 8'h03);
        repeat (2) @(posedge pclk);
        chk("prog zero", {24'h0, feedback_div, range_mult}, 32'h0000_0013);
        wr(PROG_ADDR, 8'h85);
        repeat (2) @(posedge pclk);
        chk("prog fields", {24'h0, feedback_div, range_mult}, 32'h0000_0085);
        wr(PROG_ADDR, {MUL_RESET, RANGE_PICK});
        // Source selection and its interlocks, after tracking has settled.
        wr(BW_ADDR, 8'h20);
        repeat (LOCK_CYCLES) @(posedge pclk);
        wr(CTRL_ADDR, 8'h10);
        rd(CTRL_ADDR, 32'h0000_002F, 1'b0);
        wr(CTRL_ADDR, 8'h30);
        held = base_clock_out;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (base_clock_out !== held) held = 1'bx;
        end
        chk("held in switch", {31'h0, held === base_clock_out}, 32'h0000_0001);
        period(1000);
        wr(CTRL_ADDR, 8'h10);
        rd(CTRL_ADDR, 32'h0000_003F, 1'b0);
        wr(CTRL_ADDR, 8'h20);
        period(2000);
        wr(CTRL_ADDR, 8'h00);
        wait_bit("loop off", synth_enable, 1'b0);
        wr(CTRL_ADDR, 8'h10);
        rd(CTRL_ADDR, 32'h0000_000F, 1'b0);
        wr(CTRL_ADDR, 8'h20);
        wr(CTRL_ADDR, 8'h30);
        wr(PROG_ADDR, 8'h60);
        rd(CTRL_ADDR, 32'h0000_002F, 1'b0);
        wait_bit("range zero", synth_enable, 1'b0);
        period(2000);
        wr(PROG_ADDR, 8'h67);
        wr(CTRL_ADDR, 8'h30);
        stop_req <= 1'b1;
        repeat (2) @(posedge pclk);
        stop_req <= 1'b0;
        rd(CTRL_ADDR, 32'h0000_002F, 1'b0);
        finish_test();
    end
endmodule
